// ==== rtl/ramp_time_handshake.sv ====
// Purpose: Cyclic link status bits and ramp time write handshakes
// Assumes: Master pins asynchronous to sys_clk_in; drive state inputs local
// Notes: Handshake and failure flags come from flops in the channel judges and latch; feed indicators are flopped here
`timescale 1ns/10ps

// Summary of operation
// - Position feed indicator high exactly while position feed is selected.
// - Speed feed indicator high exactly while speed feed is selected.
// - Fork indicator high exactly while fork control is selected.
// - Acceleration receipt rises once judged while its request is high.
// - Acceleration receipt drops after the request drops.
// - Acceleration not-applied high only for a rejected value.
// - Acceleration time outside 0 to 650.00 s is rejected; old kept.
// - Acceleration time written while running is rejected; old kept.
// - Acceleration not-applied drops after the request drops.
// - Deceleration receipt rises once judged while its request is high.
// - Deceleration receipt drops after the request drops.
// - Deceleration not-applied high only for a rejected value.
// - Deceleration time outside 0 to 650.00 s is rejected; old kept.
// - Deceleration time written while running is rejected; old kept.
// - Deceleration not-applied drops after the request drops.
// - System failure flag sets on detection and stays set.
// - Failure flag clears on drive reset after condition cleared, or on rst_in.
module ramp_time_handshake
	import ramp_time_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Link requests and words from the master
	input wire logic accel_time_write_req_in,
	input wire logic decel_time_write_req_in,
	input wire logic [`RAMP_TIME_W-1:0] accel_time_link_word_in,
	input wire logic [`RAMP_TIME_W-1:0] decel_time_link_word_in,
	// Drive state
	input wire logic drive_running_in,
	input wire logic [`FEED_SEL_W-1:0] feed_mode_sel_in,
	input wire logic fork_control_sel_in,
	input wire logic failure_active_in,
	input wire logic drive_reset_in,
	// Feed indicators
	output logic position_feed_active_out,
	output logic speed_feed_active_out,
	output logic fork_control_active_out,
	// Ramp handshake flags
	output logic accel_time_receipt_done_out,
	output logic accel_time_rejected_out,
	output logic decel_time_receipt_done_out,
	output logic decel_time_rejected_out,
	// Failure
	output logic system_failure_flag_out,
	// Working ramp times
	output logic [`RAMP_TIME_W-1:0] accel_time_value_out,
	output logic [`RAMP_TIME_W-1:0] decel_time_value_out
);
	// ============================================================
	// Decode helpers
	function automatic logic feed_match(input feed_sel_t sel, input feed_sel_t code);
		feed_match = (sel == code);
	endfunction

	// ============================================================
	// Link input synchronisers
	logic [`CHAN_COUNT-1:0] req_raw;
	logic [`CHAN_COUNT-1:0] req_meta;
	logic [`CHAN_COUNT-1:0] req_sync;
	ramp_time_t word_raw [`CHAN_COUNT];
	ramp_time_t word_meta [`CHAN_COUNT];
	ramp_time_t word_sync [`CHAN_COUNT];

	// Gather pins per channel
	assign req_raw[`CHAN_ACCEL] = accel_time_write_req_in;
	assign req_raw[`CHAN_DECEL] = decel_time_write_req_in;
	assign word_raw[`CHAN_ACCEL] = accel_time_link_word_in;
	assign word_raw[`CHAN_DECEL] = decel_time_link_word_in;

	// Request two-flop crossing
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			req_meta <= '0;
			req_sync <= '0;
		end else begin
			req_meta <= req_raw;
			req_sync <= req_meta;
		end
	end

	// Word crossing; safe only because the word settles before the request
	generate
		for (genvar ch = 0; ch < `CHAN_COUNT; ch++) begin : g_word_sync
			always_ff @(posedge sys_clk_in) begin
				if (rst_in) begin
					word_meta[ch] <= '0;
					word_sync[ch] <= '0;
				end else begin
					word_meta[ch] <= word_raw[ch];
					word_sync[ch] <= word_meta[ch];
				end
			end
		end
	endgenerate

	// ============================================================
	// Feed method indicators
	// Registered so the link sees clean levels
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			position_feed_active_out <= 1'b0;
			speed_feed_active_out <= 1'b0;
		end else begin
			position_feed_active_out <= feed_match(feed_mode_sel_in, `FEED_SEL_POSITION);
			speed_feed_active_out <= feed_match(feed_mode_sel_in, `FEED_SEL_SPEED);
		end
	end

	// Fork control indicator
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			fork_control_active_out <= 1'b0;
		end else begin
			fork_control_active_out <= fork_control_sel_in;
		end
	end

	// ============================================================
	// Ramp time channels
	ramp_time_if chan_if [`CHAN_COUNT] ();

	// Feed each channel; running state is shared
	generate
		for (genvar ch = 0; ch < `CHAN_COUNT; ch++) begin : g_chan
			assign chan_if[ch].req = req_sync[ch];
			assign chan_if[ch].word = word_sync[ch];
			assign chan_if[ch].running = drive_running_in;
		end
	endgenerate

	// Acceleration judge
	ramp_time_judge #(
		.RST_TIME(`ACCEL_TIME_RST)
	) u_accel_judge (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.bus(chan_if[`CHAN_ACCEL])
	);

	// Deceleration judge
	ramp_time_judge #(
		.RST_TIME(`DECEL_TIME_RST)
	) u_decel_judge (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.bus(chan_if[`CHAN_DECEL])
	);

	// Flag outputs are flops inside the judges
	assign accel_time_receipt_done_out = chan_if[`CHAN_ACCEL].receipt_done;
	assign accel_time_rejected_out = chan_if[`CHAN_ACCEL].rejected;
	assign decel_time_receipt_done_out = chan_if[`CHAN_DECEL].receipt_done;
	assign decel_time_rejected_out = chan_if[`CHAN_DECEL].rejected;
	assign accel_time_value_out = chan_if[`CHAN_ACCEL].stored_time;
	assign decel_time_value_out = chan_if[`CHAN_DECEL].stored_time;

	// ============================================================
	// System failure
	failure_latch u_failure (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.failure_active_in(failure_active_in),
		.drive_reset_in(drive_reset_in),
		.flag_out(system_failure_flag_out)
	);

	// ============================================================
	// Feed indicator checks
	chk_position_feed_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!$past(rst_in) |->
		position_feed_active_out == ($past(feed_mode_sel_in) == `FEED_SEL_POSITION))
		else $error("position feed indicator wrong");
	chk_speed_feed_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!$past(rst_in) |->
		speed_feed_active_out == ($past(feed_mode_sel_in) == `FEED_SEL_SPEED))
		else $error("speed feed indicator wrong");
	chk_feed_exclusive: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!(position_feed_active_out && speed_feed_active_out))
		else $error("both feed indicators high");
	chk_fork_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$changed(fork_control_sel_in) |=> fork_control_active_out == $past(fork_control_sel_in))
		else $error("fork indicator did not follow select");

	// ============================================================
	// Acceleration handshake checks
	chk_accel_receipt_rise: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(req_sync[`CHAN_ACCEL]) |-> ##2 accel_time_receipt_done_out)
		else $error("acceleration receipt late");
	chk_accel_receipt_fall: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$fell(req_sync[`CHAN_ACCEL]) |-> ##[1:2] !accel_time_receipt_done_out)
		else $error("acceleration receipt not cleared");
	chk_accel_reject_pair: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		accel_time_rejected_out |-> accel_time_receipt_done_out)
		else $error("acceleration not-applied without receipt");
	chk_accel_range: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		accel_time_value_out <= `RAMP_TIME_MAX_CS || $stable(accel_time_value_out))
		else $error("acceleration time took an out of range value");
	chk_accel_running: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(accel_time_receipt_done_out) && $past(drive_running_in) |->
		accel_time_rejected_out && $stable(accel_time_value_out))
		else $error("acceleration time applied while running");
	chk_accel_reject_fall: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$fell(req_sync[`CHAN_ACCEL]) |-> ##[1:2] !accel_time_rejected_out)
		else $error("acceleration not-applied not cleared");

	// ============================================================
	// Deceleration handshake checks
	chk_decel_receipt_rise: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(req_sync[`CHAN_DECEL]) |-> ##2 decel_time_receipt_done_out)
		else $error("deceleration receipt late");
	chk_decel_receipt_fall: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$fell(req_sync[`CHAN_DECEL]) |-> ##[1:2] !decel_time_receipt_done_out)
		else $error("deceleration receipt not cleared");
	chk_decel_reject_pair: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		decel_time_rejected_out |-> decel_time_receipt_done_out)
		else $error("deceleration not-applied without receipt");
	chk_decel_range: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		decel_time_value_out <= `RAMP_TIME_MAX_CS || $stable(decel_time_value_out))
		else $error("deceleration time took an out of range value");
	chk_decel_running: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(decel_time_receipt_done_out) && $past(drive_running_in) |->
		decel_time_rejected_out && $stable(decel_time_value_out))
		else $error("deceleration time applied while running");
	chk_decel_reject_fall: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$fell(req_sync[`CHAN_DECEL]) |-> ##[1:2] !decel_time_rejected_out)
		else $error("deceleration not-applied not cleared");

	// ============================================================
	// Failure flag checks
	chk_failure_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		failure_active_in |=> system_failure_flag_out)
		else $error("failure flag not set on detection");
	chk_failure_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		system_failure_flag_out && !drive_reset_in |=> system_failure_flag_out)
		else $error("failure flag dropped without drive reset");
	chk_failure_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		system_failure_flag_out && drive_reset_in && !failure_active_in |=>
		!system_failure_flag_out)
		else $error("failure flag not cleared by drive reset");
endmodule

// ==== rtl/ramp_time_defines.svh ====
// Purpose: Constants for the ramp time write handshake block
// Assumes: Ramp times carried as unsigned centiseconds in a 16-bit word
// Notes: Definitions only, no logic
`ifndef RAMP_TIME_DEFINES_SVH
`define RAMP_TIME_DEFINES_SVH

// ============================================================
// Ramp time limits and reset values
`define RAMP_TIME_W 16
// Upper limit 650.00 s in 0.01 s units
`define RAMP_TIME_MAX_CS 16'hFDE8
// Stored times after reset, plain defaults
`define ACCEL_TIME_RST 16'h01F4
`define DECEL_TIME_RST 16'h01F4

// ============================================================
// Feed method select codes
`define FEED_SEL_W 2
`define FEED_SEL_NONE 2'h0
`define FEED_SEL_POSITION 2'h1
`define FEED_SEL_SPEED 2'h2

// ============================================================
// Channel numbering
`define CHAN_COUNT 2
`define CHAN_ACCEL 0
`define CHAN_DECEL 1

`endif

// ==== rtl/ramp_time_pkg.sv ====
// Purpose: Shared types for the ramp time write handshake block
// Assumes: Constants come from ramp_time_defines.svh
// Notes: Types only
`include "ramp_time_defines.svh"

package ramp_time_pkg;
	// ============================================================
	// Types
	typedef logic [`RAMP_TIME_W-1:0] ramp_time_t;
	typedef logic [`FEED_SEL_W-1:0] feed_sel_t;
	typedef enum logic [1:0] {JUDGE_IDLE, JUDGE_EVAL, JUDGE_HOLD} judge_state_t;
endpackage

// ==== rtl/ramp_time_if.sv ====
// Purpose: Bundle between the top and one ramp time judge channel
// Assumes: Request and word already synchronised by the top
// Notes: One instance per channel
`timescale 1ns/10ps

interface ramp_time_if;
	import ramp_time_pkg::*;
	// ============================================================
	// Channel signals
	logic req;
	ramp_time_t word;
	logic running;
	logic receipt_done;
	logic rejected;
	ramp_time_t stored_time;

	modport judge (input req, input word, input running,
		output receipt_done, output rejected, output stored_time);
	modport ctrl (output req, output word, output running,
		input receipt_done, input rejected, input stored_time);
endinterface

// ==== rtl/ramp_time_judge.sv ====
// Purpose: Judges one written ramp time and runs its receipt handshake
// Assumes: Request and word stable and synchronised on sys_clk_in
// Notes: Two cycles from request seen high to receipt flag
`timescale 1ns/10ps

module ramp_time_judge
	import ramp_time_pkg::*;
#(
	parameter ramp_time_t RST_TIME = `ACCEL_TIME_RST
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Channel bundle
	ramp_time_if.judge bus
);
	// ============================================================
	// Judgement
	judge_state_t state;
	logic reject_now;

	// Out of range or written while running; below zero cannot be encoded
	assign reject_now = (bus.word > `RAMP_TIME_MAX_CS) || bus.running;

	// Handshake sequencer
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state <= JUDGE_IDLE;
		end else begin
			unique case (state)
				JUDGE_IDLE: if (bus.req) state <= JUDGE_EVAL;
				JUDGE_EVAL: state <= JUDGE_HOLD;
				JUDGE_HOLD: if (!bus.req) state <= JUDGE_IDLE;
				default: state <= JUDGE_IDLE;
			endcase
		end
	end

	// Flags raised after judging, dropped once the request goes away
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			bus.receipt_done <= 1'b0;
			bus.rejected <= 1'b0;
		end else if (state == JUDGE_EVAL) begin
			bus.receipt_done <= 1'b1;
			bus.rejected <= reject_now;
		end else if (state == JUDGE_HOLD && !bus.req) begin
			bus.receipt_done <= 1'b0;
			bus.rejected <= 1'b0;
		end
	end

	// Stored time replaced in the same step that raises receipt
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			bus.stored_time <= RST_TIME;
		end else if (state == JUDGE_EVAL && !reject_now) begin
			bus.stored_time <= bus.word;
		end
	end

	// ============================================================
	// Checks
	chk_reject_cause: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(bus.receipt_done) |->
		bus.rejected == (($past(bus.word) > `RAMP_TIME_MAX_CS) || $past(bus.running)))
		else $error("rejected flag does not match judged cause");
	chk_keep_old: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(bus.receipt_done) && bus.rejected |-> $stable(bus.stored_time))
		else $error("stored time changed on a rejected write");
	chk_take_new: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(bus.receipt_done) && !bus.rejected |-> bus.stored_time == $past(bus.word))
		else $error("accepted time not stored with receipt");
endmodule

// ==== rtl/failure_latch.sv ====
// Purpose: Sticky system failure flag
// Assumes: Condition and drive reset come from logic on sys_clk_in
// Notes: Clear needs a drive reset while the condition is gone
`timescale 1ns/10ps

module failure_latch (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Failure sources
	input wire logic failure_active_in,
	input wire logic drive_reset_in,
	// Flag
	output logic flag_out
);
	// ============================================================
	// Latch; set wins so a renewed failure is never lost
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			flag_out <= 1'b0;
		end else if (failure_active_in) begin
			flag_out <= 1'b1;
		end else if (drive_reset_in) begin
			flag_out <= 1'b0;
		end
	end
endmodule

// ==== tb/link_master_model.sv ====
// Purpose: Behavioural fieldbus master for one ramp time write channel
// Assumes: Bench pulses go_in for one cycle with the new word
// Notes: Drives shortly after the rising edge, samples on it
`timescale 1ns/10ps

module link_master_model (
	// Clock
	input wire logic sys_clk_in,
	// Commands from the bench
	input wire logic go_in,
	input wire logic [15:0] word_in,
	// Device answer
	input wire logic receipt_in,
	input wire logic rejected_in,
	// Link side
	output logic req_out,
	output logic [15:0] word_out,
	// Outcome for the bench
	output logic done_out,
	output logic seen_out,
	output logic rej_out
);
	int n;

	// ============================================================
	// One write transfer per go pulse
	initial begin
		req_out = 1'b0;
		word_out = 16'h0000;
		done_out = 1'b0;
		seen_out = 1'b0;
		rej_out = 1'b0;
		forever begin
			@(posedge sys_clk_in);
			if (go_in === 1'b1) begin
				#1 word_out = word_in; // Word settles before request
				done_out = 1'b0;
				seen_out = 1'b0;
				repeat (2) @(posedge sys_clk_in);
				#1 req_out = 1'b1;
				n = 0;
				// Bounded so a silent device cannot hang the run
				while (seen_out !== 1'b1 && n < 20) begin
					@(posedge sys_clk_in);
					n++;
					seen_out = receipt_in;
				end
				rej_out = rejected_in; // Not-applied taken with receipt
				#1 req_out = 1'b0; // Drop after receipt, or after 20 cycles without one
				word_out = ~word_out; // Released word must not keep its value
				done_out = 1'b1;
			end
		end
	end
endmodule

// ==== tb/ramp_time_write_handshake_tb.sv ====
// Purpose: Self-checking bench for the ramp time write handshake block
// Assumes: Design assertions run alongside; masters are behavioural
// Notes: Table rows for writes, hand tests for feed, failure and reset
`timescale 1ns/10ps
`include "ramp_time_defines.svh"

module ramp_time_write_handshake_tb;
	import ramp_time_pkg::*;

	typedef struct {logic ch; logic [15:0] w; logic run; logic rej;} row_t;

	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic running = 1'b0;
	logic [1:0] sel = 2'h0;
	logic fork_sel = 1'b0;
	logic fail = 1'b0;
	logic dreset = 1'b0;
	logic [1:0] go = 2'b00;
	logic [15:0] wd [2] = '{16'h0000, 16'h0000};
	logic [1:0] req, done, seen, rej_seen, rcpt, rjct;
	logic [15:0] lw [2];
	logic pos, spd, frk, sfail;
	logic [15:0] accel_val, decel_val;
	logic [15:0] exp_val [2];
	int n_errors = 0;
	int n_compared = 0;
	row_t rows [8] = '{'{0, 16'h0000, 0, 0}, '{0, 16'hFDE8, 0, 0}, '{0, 16'hFDE9, 0, 1},
		'{0, 16'h0BB8, 1, 1}, '{1, 16'hFFFF, 0, 1}, '{1, 16'hFDE8, 0, 0},
		'{1, 16'h0000, 1, 1}, '{1, 16'h0001, 0, 0}};

	// ============================================================
	// Clock and design
	initial begin
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	ramp_time_handshake DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.accel_time_write_req_in(req[0]), .decel_time_write_req_in(req[1]),
		.accel_time_link_word_in(lw[0]), .decel_time_link_word_in(lw[1]),
		.drive_running_in(running), .feed_mode_sel_in(sel), .fork_control_sel_in(fork_sel),
		.failure_active_in(fail), .drive_reset_in(dreset),
		.position_feed_active_out(pos), .speed_feed_active_out(spd),
		.fork_control_active_out(frk),
		.accel_time_receipt_done_out(rcpt[0]), .accel_time_rejected_out(rjct[0]),
		.decel_time_receipt_done_out(rcpt[1]), .decel_time_rejected_out(rjct[1]),
		.system_failure_flag_out(sfail),
		.accel_time_value_out(accel_val), .decel_time_value_out(decel_val));

	// One master per channel, the two run independently
	link_master_model m_accel (.sys_clk_in(sys_clk_in), .go_in(go[0]), .word_in(wd[0]),
		.receipt_in(rcpt[0]), .rejected_in(rjct[0]), .req_out(req[0]), .word_out(lw[0]),
		.done_out(done[0]), .seen_out(seen[0]), .rej_out(rej_seen[0]));
	link_master_model m_decel (.sys_clk_in(sys_clk_in), .go_in(go[1]), .word_in(wd[1]),
		.receipt_in(rcpt[1]), .rejected_in(rjct[1]), .req_out(req[1]), .word_out(lw[1]),
		.done_out(done[1]), .seen_out(seen[1]), .rej_out(rej_seen[1]));

	// ============================================================
	// Shared tasks
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask

	task automatic print_verdict();
		if (n_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic launch(input logic [1:0] m, input logic [15:0] a, input logic [15:0] d,
		input logic run);
		@(posedge sys_clk_in);
		#1 go = m;
		wd[0] = a;
		wd[1] = d;
		running = run;
		@(posedge sys_clk_in);
		#1 go = 2'b00;
		// Let the master clear its stale done flag before anyone polls it
		@(posedge sys_clk_in);
	endtask

	// Waits for the master, then checks outcome, stored time and flag release
	task automatic finish(input int ch, input logic rej);
		int n;
		logic [15:0] got;
		n = 0;
		while (done[ch] !== 1'b1 && n < 40) begin
			@(posedge sys_clk_in);
			n++;
		end
		if (n >= 40) begin
			$display("[ERR] transfer done expected 1 seen %b", done[ch]);
			n_errors++;
			print_verdict();
		end
		chk("receipt seen", 16'h0001, {15'h0, seen[ch]});
		chk("not applied", {15'h0, rej}, {15'h0, rej_seen[ch]});
		if (!rej) exp_val[ch] = wd[ch];
		got = ch ? decel_val : accel_val;
		chk("stored time", exp_val[ch], got);
		n = 0;
		while ((rcpt[ch] !== 1'b0 || rjct[ch] !== 1'b0) && n < 6) begin
			@(posedge sys_clk_in);
			n++;
		end
		chk("flags cleared", 16'h0001, {15'h0, n < 6});
	endtask

	// ============================================================
	// Main sequence
	initial begin
		exp_val[0] = `ACCEL_TIME_RST;
		exp_val[1] = `DECEL_TIME_RST;
		repeat (5) @(posedge sys_clk_in);
		#1 rst_in = 1'b0;
		// Table: boundaries of the range, running, both channels
		foreach (rows[i]) begin
			launch(rows[i].ch ? 2'b10 : 2'b01, rows[i].w, rows[i].w, rows[i].run);
			finish(int'(rows[i].ch), rows[i].rej);
		end
		// Both channels overlapping, different words
		launch(2'b11, 16'h0100, 16'h0200, 1'b0);
		finish(0, 1'b0);
		finish(1, 1'b0);
		// Every feed select code with fork on and off
		for (int i = 0; i < 8; i++) begin
			#1 sel = i[1:0];
			fork_sel = i[2];
			@(posedge sys_clk_in);
			@(posedge sys_clk_in);
			#1 chk("position feed", {15'h0, sel == 2'h1}, {15'h0, pos});
			chk("speed feed", {15'h0, sel == 2'h2}, {15'h0, spd});
			chk("fork", {15'h0, fork_sel}, {15'h0, frk});
		end
		// Failure: set, sticky, reset ignored while active, then cleared
		fail = 1'b1;
		repeat (2) @(posedge sys_clk_in);
		#1 fail = 1'b0;
		chk("failure set", 16'h0001, {15'h0, sfail});
		repeat (3) @(posedge sys_clk_in);
		#1 chk("failure held", 16'h0001, {15'h0, sfail});
		fail = 1'b1;
		dreset = 1'b1;
		repeat (2) @(posedge sys_clk_in);
		#1 chk("failure kept", 16'h0001, {15'h0, sfail});
		fail = 1'b0;
		repeat (2) @(posedge sys_clk_in);
		#1 chk("failure cleared", 16'h0000, {15'h0, sfail});
		dreset = 1'b0;
		// Reset in mid-run with failure and non-default times
		fail = 1'b1;
		@(posedge sys_clk_in);
		#1 rst_in = 1'b1;
		@(posedge sys_clk_in);
		#1 chk("accel after reset", `ACCEL_TIME_RST, accel_val);
		chk("decel after reset", `DECEL_TIME_RST, decel_val);
		chk("failure in reset", 16'h0000, {15'h0, sfail});
		fail = 1'b0;
		rst_in = 1'b0;
		exp_val[0] = `ACCEL_TIME_RST;
		exp_val[1] = `DECEL_TIME_RST;
		// Running write right after reset keeps the default
		launch(2'b10, 16'h0005, 16'h0005, 1'b1);
		finish(1, 1'b1);
		print_verdict();
	end
endmodule
